// >>> rtl/pit_unit.v
// Purpose: One 16-bit presettable down counter with latch, status and byte sequencing
// Assumes: Host strobes are one-cycle pulses on sys_clk_i; pins arrive asynchronous
// Notes: Modes 0 to 5, binary or BCD
`timescale 1ns/1ns
`include "pit_map.vh"
module pit_unit (
    // Clock and reset
    input wire sys_clk_i,
    input wire nrst_i,
    // Host side
    input wire wr_data_i,
    input wire rd_data_i,
    input wire [7:0] wdata_i,
    input wire setup_i,
    input wire [5:0] setup_bits_i,
    input wire latch_cnt_i,
    input wire latch_sta_i,
    output wire [7:0] rdata_o,
    // Field pins
    input wire cnt_clk_i,
    input wire gate_i,
    output wire out_o
);
    reg [1:0] acc_mode;
    reg [2:0] op_mode;
    reg fmt_bcd;
    reg [15:0] preset;
    reg [15:0] count;
    reg [15:0] hold;
    reg [7:0] sta_hold;
    reg cnt_held;
    reg sta_held;
    reg rd_toggle;
    reg wr_toggle;
    reg null_cnt;
    reg load_pend;
    reg armed;
    reg run;
    reg out;
    reg clk_d;
    reg gate_d;
    reg trig;
    wire [15:0] next_count;
    wire clk_s;
    wire gate_s;
    wire tick;
    wire gate_rise;
    wire [1:0] mode_eff;
    wire [7:0] status_byte;
    reg [7:0] rdata;

    pit_sync u_sync_clk (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .d_i(cnt_clk_i),
        .q_o(clk_s)
    );
    pit_sync u_sync_gate (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .d_i(gate_i),
        .q_o(gate_s)
    );

    assign tick = clk_s & ~clk_d;
    assign gate_rise = gate_s & ~gate_d;
    assign mode_eff = op_mode[1:0];
    assign status_byte = {out, null_cnt, acc_mode, op_mode, fmt_bcd};
    assign out_o = out;
    assign rdata_o = rdata;

    // Decrement by a step in binary or BCD
    function [15:0] dec;
        input [15:0] v;
        input bcd;
        input [1:0] step;
        reg [15:0] r;
        integer i;
        begin
            r = v;
            for (i = 0; i < 2; i = i + 1) begin
                if (i < step) begin
                    if (!bcd) begin
                        r = r - 16'h0001;
                    end else if (r[3:0] != 4'h0) begin
                        r[3:0] = r[3:0] - 4'h1;
                    end else if (r[7:4] != 4'h0) begin
                        r[7:0] = {r[7:4] - 4'h1, 4'h9};
                    end else if (r[11:8] != 4'h0) begin
                        r[11:0] = {r[11:8] - 4'h1, 8'h99};
                    end else if (r[15:12] != 4'h0) begin
                        r = {r[15:12] - 4'h1, 12'h999};
                    end else begin
                        r = 16'h9999;
                    end
                end
            end
            dec = r;
        end
    endfunction

    assign next_count = dec(count, fmt_bcd, 2'h1);

    // Read mux with status first, then held or live bytes
    always @* begin
        if (sta_held) begin
            rdata = sta_hold;
        end else begin
            case (acc_mode)
                `PIT_ACC_MSB: rdata = cnt_held ? hold[15:8] : count[15:8];
                `PIT_ACC_PAIR: rdata = rd_toggle ? (cnt_held ? hold[15:8] : count[15:8])
                                                 : (cnt_held ? hold[7:0] : count[7:0]);
                default: rdata = cnt_held ? hold[7:0] : count[7:0];
            endcase
        end
    end

    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            acc_mode <= `PIT_RST_ACC;
            op_mode <= `PIT_RST_MODE;
            fmt_bcd <= 1'b0;
            preset <= `PIT_RST_COUNT;
            count <= `PIT_RST_COUNT;
            hold <= `PIT_RST_COUNT;
            sta_hold <= 8'h00;
            cnt_held <= 1'b0;
            sta_held <= 1'b0;
            rd_toggle <= 1'b0;
            wr_toggle <= 1'b0;
            null_cnt <= 1'b0;
            load_pend <= 1'b0;
            armed <= 1'b0;
            run <= 1'b0;
            out <= 1'b1;
            clk_d <= 1'b0;
            gate_d <= 1'b0;
            trig <= 1'b0;
        end else begin
            clk_d <= clk_s;
            gate_d <= gate_s;
            if (gate_rise) begin
                trig <= 1'b1;
            end
            // Latch commands
            if (latch_cnt_i && !cnt_held) begin
                hold <= count;
                cnt_held <= 1'b1;
            end
            if (latch_sta_i && !sta_held) begin
                sta_hold <= status_byte;
                sta_held <= 1'b1;
            end
            // Host reads
            if (rd_data_i) begin
                if (sta_held) begin
                    sta_held <= 1'b0;
                end else if (acc_mode == `PIT_ACC_PAIR) begin
                    rd_toggle <= ~rd_toggle;
                    if (rd_toggle) begin
                        cnt_held <= 1'b0;
                    end
                end else begin
                    cnt_held <= 1'b0;
                end
            end
            // Setup byte
            if (setup_i) begin
                acc_mode <= setup_bits_i[5:4];
                op_mode <= setup_bits_i[3:1];
                fmt_bcd <= setup_bits_i[0];
                cnt_held <= 1'b0;
                sta_held <= 1'b0;
                rd_toggle <= 1'b0;
                wr_toggle <= 1'b0;
                armed <= 1'b0;
                run <= 1'b0;
                trig <= 1'b0;
                out <= (setup_bits_i[3:1] != 3'h0);
            end else if (wr_data_i) begin
                // Count write: low byte first in pair mode
                case (acc_mode)
                    `PIT_ACC_LSB: preset <= {8'h00, wdata_i};
                    `PIT_ACC_MSB: preset <= {wdata_i, 8'h00};
                    default: begin
                        if (!wr_toggle) begin
                            preset[7:0] <= wdata_i;
                        end else begin
                            preset[15:8] <= wdata_i;
                        end
                    end
                endcase
                if (acc_mode == `PIT_ACC_PAIR) begin
                    wr_toggle <= ~wr_toggle;
                end
                if (acc_mode != `PIT_ACC_PAIR || wr_toggle) begin
                    null_cnt <= 1'b1;
                    load_pend <= 1'b1;
                    armed <= 1'b1;
                    if (op_mode == 3'h0) begin
                        out <= 1'b0;
                        run <= 1'b0;
                    end
                end
            end else if (tick) begin
                trig <= 1'b0;
                if (op_mode[1]) begin
                    // Modes 2 and 3 run while gated, reload on trigger or pending load
                    if (!gate_s) begin
                        out <= 1'b1;
                        run <= 1'b0;
                    end else if (!run && armed) begin
                        count <= preset;
                        null_cnt <= 1'b0;
                        load_pend <= 1'b0;
                        run <= 1'b1;
                        out <= 1'b1;
                    end else if (run && mode_eff == 2'h2) begin
                        if (count == 16'h0002 || (count == 16'h0001 && !out)) begin
                            out <= ~out;
                            if (count == 16'h0001) begin
                                count <= preset;
                                null_cnt <= 1'b0;
                                load_pend <= 1'b0;
                            end else begin
                                count <= next_count;
                            end
                        end else if (count == 16'h0001) begin
                            count <= preset;
                            null_cnt <= 1'b0;
                        end else begin
                            count <= next_count;
                        end
                    end else if (run) begin
                        // Square wave: extra step on odd count in high half
                        if (count == 16'h0002 || count == 16'h0001) begin
                            out <= ~out;
                            count <= out ? {preset[15:1], 1'b0} : preset;
                            null_cnt <= 1'b0;
                            load_pend <= 1'b0;
                        end else begin
                            count <= dec(count, fmt_bcd, 2'h2);
                        end
                    end
                end else begin
                    // One-shot family: modes 0, 1, 4, 5
                    if (load_pend && (op_mode == 3'h0 || op_mode == 3'h4)) begin
                        count <= preset;
                        null_cnt <= 1'b0;
                        load_pend <= 1'b0;
                        run <= 1'b1;
                        out <= (op_mode == 3'h4) ? 1'b1 : 1'b0;
                    end else if ((trig || gate_rise) && armed && op_mode[0]) begin
                        count <= preset;
                        null_cnt <= 1'b0;
                        load_pend <= 1'b0;
                        run <= 1'b1;
                        out <= op_mode[2];
                    end else if (run && (gate_s || op_mode[0])) begin
                        if (op_mode[2]) begin
                            if (!out) begin
                                out <= 1'b1;
                                run <= 1'b0;
                            end else if (count == 16'h0001) begin
                                out <= 1'b0;
                                count <= next_count;
                            end else begin
                                count <= next_count;
                            end
                        end else begin
                            count <= next_count;
                            if (count == 16'h0001) begin
                                out <= 1'b1;
                                run <= 1'b0;
                            end
                        end
                    end else if (gate_s || op_mode[0]) begin
                        count <= next_count;
                    end
                end
            end
            // Modes 2 and 3 stop at once when the gate drops
            if (op_mode[1] && !gate_s && !setup_i) begin
                out <= 1'b1;
                run <= 1'b0;
            end
        end
    end
endmodule

// >>> rtl/pit_map.vh
// Purpose: Register offsets, control byte fields and reset values of the interval timer
// Assumes: Byte-wide host port, offsets as seen by the host
// Notes: Included by the unit and core design files
`ifndef PIT_MAP_VH
`define PIT_MAP_VH
`define PIT_OFS_UNIT0 8'h10
`define PIT_OFS_UNIT1 8'h11
`define PIT_OFS_UNIT2 8'h12
`define PIT_OFS_SETUP 8'h13
`define PIT_SEL_HI 7
`define PIT_SEL_LO 6
`define PIT_ACC_HI 5
`define PIT_ACC_LO 4
`define PIT_MODE_HI 3
`define PIT_MODE_LO 1
`define PIT_FMT_BIT 0
`define PIT_SEL_RDBK 2'h3
`define PIT_ACC_LATCH 2'h0
`define PIT_ACC_LSB 2'h1
`define PIT_ACC_MSB 2'h2
`define PIT_ACC_PAIR 2'h3
`define PIT_RB_CNT_N 5
`define PIT_RB_STA_N 4
`define PIT_RST_ACC 2'h1
`define PIT_RST_MODE 3'h0
`define PIT_RST_COUNT 16'h0000
`endif

// >>> rtl/pit_sync.v
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Input is asynchronous to sys_clk_i
// Notes: First stage is read only by second stage
`timescale 1ns/1ns
module pit_sync (
    // Clock and reset
    input wire sys_clk_i,
    input wire nrst_i,
    // Data
    input wire d_i,
    output wire q_o
);
    reg s1;
    reg s2;
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
        end
    end
    assign q_o = s2;
endmodule

// >>> rtl/pit_core.v
// Purpose: Three-counter interval timer behind a byte-wide host port
// Assumes: One-cycle read and write strobes, address stable with them
// Notes: Readback command latches selected counters in the same cycle
`timescale 1ns/1ns
`include "pit_map.vh"
module pit_core (
    // Clock and reset
    input wire sys_clk_i,
    input wire nrst_i,
    // Host port
    input wire [7:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    // Field pins
    input wire [2:0] cnt_clk_i,
    input wire [2:0] gate_i,
    output wire [2:0] out_o
);
    wire [7:0] unit_rd [0:2];
    wire [7:0] ofs [0:2];
    wire setup_wr;
    wire rdbk;
    wire [1:0] sel;
    assign ofs[0] = `PIT_OFS_UNIT0;
    assign ofs[1] = `PIT_OFS_UNIT1;
    assign ofs[2] = `PIT_OFS_UNIT2;
    assign setup_wr = wr_i && (addr_i == `PIT_OFS_SETUP);
    assign sel = wdata_i[`PIT_SEL_HI:`PIT_SEL_LO];
    assign rdbk = setup_wr && (sel == `PIT_SEL_RDBK) && !wdata_i[0];

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_unit
            wire mine;
            assign mine = setup_wr && (sel == g);
            pit_unit u_unit (
                .sys_clk_i(sys_clk_i),
                .nrst_i(nrst_i),
                .wr_data_i(wr_i && (addr_i == ofs[g])),
                .rd_data_i(rd_i && (addr_i == ofs[g])),
                .wdata_i(wdata_i),
                .setup_i(mine && (wdata_i[5:4] != `PIT_ACC_LATCH)),
                .setup_bits_i(wdata_i[5:0]),
                .latch_cnt_i((mine && wdata_i[5:4] == `PIT_ACC_LATCH)
                    || (rdbk && !wdata_i[`PIT_RB_CNT_N] && wdata_i[g+1])),
                .latch_sta_i(rdbk && !wdata_i[`PIT_RB_STA_N] && wdata_i[g+1]),
                .rdata_o(unit_rd[g]),
                .cnt_clk_i(cnt_clk_i[g]),
                .gate_i(gate_i[g]),
                .out_o(out_o[g])
            );
        end
    endgenerate

    // Registered read data; unmapped reads return zero
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `PIT_OFS_UNIT0: rdata_o <= unit_rd[0];
                `PIT_OFS_UNIT1: rdata_o <= unit_rd[1];
                `PIT_OFS_UNIT2: rdata_o <= unit_rd[2];
                default: rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// >>> dv/pit_properties.sv
// Purpose: Port properties of the interval timer
// Assumes: Sees the pit_core ports only
// Notes: Counter modes are tracked from setup writes
`timescale 1ns/1ns
module pit_properties (
    // Clock and reset
    input wire sys_clk_i,
    input wire nrst_i,
    // Host port
    input wire [7:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] wdata_i,
    input wire [7:0] rdata_o,
    // Field pins
    input wire [2:0] cnt_clk_i,
    input wire [2:0] gate_i,
    input wire [2:0] out_o
);
    reg [2:0] md [0:2];
    wire setup;
    genvar k;
    assign setup = wr_i && addr_i == 8'h13 && wdata_i[7:6] != 2'h3 && wdata_i[5:4] != 2'h0;
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            md[0] <= 3'h0;
            md[1] <= 3'h0;
            md[2] <= 3'h0;
        end else if (setup) begin
            md[wdata_i[7:6]] <= wdata_i[3:1];
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    sequence s_strobe_setup(n);
        setup && wdata_i[7:6] == n && wdata_i[3:2] == 2'h2;
    endsequence
    sequence s_gate_idle(g, m);
        (m && !g) [*5];
    endsequence
    AST_RST_OUT: assert property ($rose(nrst_i) |-> out_o == 3'h7)
        else $error("Outputs not high after reset");
    AST_RST_RDATA: assert property ($rose(nrst_i) |-> rdata_o == 8'h00)
        else $error("Read data not clear after reset");
    AST_RDATA_STANDS: assert property (!rd_i |=> $stable(rdata_o))
        else $error("Read data moved without a read");
    AST_UNMAPPED_ZERO: assert property (rd_i && (addr_i < 8'h10 || addr_i > 8'h12)
        |=> rdata_o == 8'h00) else $error("Unmapped read not zero");
    generate
        for (k = 0; k < 3; k = k + 1) begin : g_unit
            wire rate;
            wire sq;
            assign rate = md[k][1:0] == 2'h2;
            assign sq = md[k][1:0] == 2'h3;
            AST_STROBE_SHORT: assert property (
                $fell(out_o[k]) && (rate || md[k][2:1] == 2'h2)
                |-> ##[1:12] out_o[k]) else $error("Strobe held low too long");
            AST_GATE_HOLDS_HIGH: assert property (s_gate_idle(gate_i[k], rate || sq)
                |-> out_o[k]) else $error("Output low while gate low");
            AST_STROBE_IDLE: assert property (s_strobe_setup(k)
                |-> ##2 out_o[k] [*4]) else $error("Strobe output not idle high");
            AST_TRIGGER_WAITS: assert property (md[k] == 3'h5 && $rose(gate_i[k])
                |-> ##4 out_o[k] [*4]) else $error("Strobe before full count");
        end
    endgenerate
endmodule
bind pit_core pit_properties pit_properties_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .cnt_clk_i(cnt_clk_i), .gate_i(gate_i),
    .out_o(out_o)
);

// >>> dv/pit_field_model.sv
// Purpose: Field side of the timer: counter clock and gate pins
// Assumes: Runs from the bench clock
// Notes: One counter clock tick is eight system clocks
`timescale 1ns/1ns
module pit_field_model (
    // Clock
    input wire sys_clk_i,
    // Gate levels asked by the bench
    input wire [2:0] gate_req_i,
    // Pins
    output reg [2:0] cnt_clk_o = 3'h0,
    output reg [2:0] gate_o = 3'h0
);
    reg [2:0] div = 3'h0;
    always @(posedge sys_clk_i) begin
        div <= div + 3'h1;
        // Positive pulses, period twice the minimum
        cnt_clk_o <= {3{div[2]}};
        // Gate level, rising edge is the trigger
        gate_o <= gate_req_i;
    end
endmodule

// >>> dv/pit_core_tb.sv
// Purpose: Self-checking bench of the interval timer
// Assumes: Field model makes eight-clock ticks
// Notes: Random counts from an xorshift with a fixed seed
`timescale 1ns/1ns
module pit_core_tb;
    localparam [47:0] FIXR = {16'h0012, 16'h0100, 16'h0007};
    localparam [47:0] FIXT = {16'd12, 16'd256, 16'd7};
    localparam [35:0] CTLS = {6'h36, 6'h3c, 6'h3e, 6'h35, 6'h24, 6'h14};
    reg sys_clk = 1'b0;
    reg nrst = 1'b0;
    reg [7:0] addr = 8'h00;
    reg host_wr = 1'b0;
    reg host_rd = 1'b0;
    reg [7:0] wdata = 8'h00;
    reg [2:0] gate_req = 3'h0;
    wire [7:0] rdata;
    wire [2:0] cnt_clk;
    wire [2:0] gate;
    wire [2:0] out;
    integer err_total = 0;
    integer cmp_count = 0;
    integer i;
    integer k;
    reg [31:0] seed = 32'h26cb;
    reg [5:0] c6;
    reg [7:0] b0;
    reg [15:0] va, vb, c, lo, hi, rv, tv;
    pit_core pit_core_inst (.sys_clk_i(sys_clk), .nrst_i(nrst), .addr_i(addr), .wr_i(host_wr),
        .rd_i(host_rd), .wdata_i(wdata), .rdata_o(rdata), .cnt_clk_i(cnt_clk),
        .gate_i(gate), .out_o(out));
    pit_field_model pit_field_model_inst (.sys_clk_i(sys_clk), .gate_req_i(gate_req),
        .cnt_clk_o(cnt_clk), .gate_o(gate));
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    function [15:0] exp_low(input [5:0] m, input [15:0] n);
        begin
            exp_low = (m[2:1] == 2'h3) ? (n >> 1) * 16'd8 : 16'd8;
        end
    endfunction
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("BAD %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task results;
        begin
            $display("Checks %0d mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    task hw(input [7:0] a, input [7:0] d);
        begin
            @(negedge sys_clk);
            addr = a;
            wdata = d;
            host_wr = 1'b1;
            @(negedge sys_clk);
            host_wr = 1'b0;
        end
    endtask
    task hr(input [7:0] a, output [7:0] d);
        begin
            @(negedge sys_clk);
            addr = a;
            host_rd = 1'b1;
            @(negedge sys_clk);
            host_rd = 1'b0;
            @(posedge sys_clk);
            #1 d = rdata;
        end
    endtask
    task hr16(input [7:0] a, output [15:0] v);
        reg [7:0] l;
        reg [7:0] h;
        begin
            hr(a, l);
            hr(a, h);
            v = {h, l};
        end
    endtask
    task load(input [1:0] u, input [1:0] acc, input [15:0] v);
        begin
            if (acc[0]) hw(8'h10 | {6'h0, u}, v[7:0]);
            if (acc[1]) hw(8'h10 | {6'h0, u}, v[15:8]);
        end
    endtask
    task wl(input integer u, input v, input [15:0] lim, output [15:0] n);
        begin
            n = 16'h0;
            while (out[u] !== v && n < lim) begin
                @(negedge sys_clk);
                n = n + 16'h1;
            end
        end
    endtask
    task rst;
        begin
            nrst = 1'b0;
            repeat (10) @(negedge sys_clk);
            nrst = 1'b1;
            @(negedge sys_clk);
            chk("out reset", {13'h0, out}, 16'h7);
            chk("rdata reset", {8'h0, rdata}, 16'h0);
        end
    endtask
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #(60000 * 50);
        err_total = err_total + 1;
        results;
    end
    initial begin
        rst;
        gate_req = 3'h7;
        for (i = 0; i < 6; i = i + 1) begin
            k = i % 3;
            c6 = CTLS[i*6 +: 6];
            seed = xs(seed);
            rv = {11'h0, seed[4:0]} + 16'h5;
            rv[0] = (i == 3);
            rv = (i < 3) ? FIXR[i*16 +: 16] : rv;
            tv = (i < 3) ? FIXT[i*16 +: 16] : rv;
            hw(8'h13, {k[1:0], c6});
            load(k[1:0], c6[5:4], rv);
            wl(k, 0, 9000, c);
            wl(k, 1, 9000, c);
            wl(k, 0, 9000, c);
            wl(k, 1, 9000, lo);
            wl(k, 0, 9000, hi);
            chk("low span", lo, exp_low(c6, tv));
            chk("period", lo + hi, tv * 16'd8);
            $display("Periodic test %0d done", i);
        end
        hw(8'h13, 8'h98);
        hw(8'h12, 8'h05);
        wl(2, 0, 400, c);
        chk("m4 delay", {15'h0, c >= 16'd40 && c <= 16'd80}, 16'h1);
        wl(2, 1, 100, lo);
        chk("m4 width", lo, 16'd8);
        wl(2, 0, 200, c);
        chk("m4 once", c, 16'd200);
        gate_req = 3'h3;
        hw(8'h13, 8'h9a);
        hw(8'h12, 8'h04);
        wl(2, 0, 100, c);
        chk("m5 wait", c, 16'd100);
        gate_req = 3'h7;
        wl(2, 0, 400, c);
        chk("m5 delay", {15'h0, c >= 16'd32 && c <= 16'd72}, 16'h1);
        wl(2, 1, 100, lo);
        chk("m5 width", lo, 16'd8);
        $display("Strobe tests done");
        gate_req = 3'h1;
        hw(8'h13, 8'h74);
        hw(8'h13, 8'hb4);
        load(2'h1, 2'h3, 16'h1234);
        load(2'h2, 2'h3, 16'h1234);
        hw(8'h13, 8'hec);
        hr(8'h11, b0);
        chk("status 1", {8'h0, b0}, 16'hf4);
        hr(8'h12, b0);
        chk("status 2", {8'h0, b0}, 16'hf4);
        gate_req = 3'h7;
        repeat (100) @(negedge sys_clk);
        hw(8'h13, 8'hdc);
        hr16(8'h11, va);
        hr16(8'h12, vb);
        chk("joint latch", va, vb);
        chk("counted", {15'h0, va < 16'h1234}, 16'h1);
        gate_req = 3'h1;
        repeat (40) @(negedge sys_clk);
        hr16(8'h11, va);
        hw(8'h13, 8'h40);
        gate_req = 3'h7;
        repeat (40) @(negedge sys_clk);
        gate_req = 3'h1;
        repeat (40) @(negedge sys_clk);
        hw(8'h13, 8'h40);
        hw(8'h13, 8'he4);
        hr(8'h11, b0);
        chk("status 3", {8'h0, b0}, 16'hb4);
        hr16(8'h11, vb);
        chk("held", vb, va);
        hr16(8'h11, vb);
        chk("moved", {15'h0, vb < 16'h1234 && vb > va}, 16'h1);
        hw(8'h20, 8'hff);
        hr(8'h20, b0);
        chk("unmapped", {8'h0, b0}, 16'h0);
        hr(8'h13, b0);
        chk("setup read", {8'h0, b0}, 16'h0);
        $display("Latch tests done");
        hw(8'h13, 8'h10);
        hw(8'h10, 8'h03);
        wl(0, 1, 200, c);
        chk("m0 delay", {15'h0, c >= 16'd24 && c <= 16'd40}, 16'h1);
        wl(0, 0, 100, c);
        chk("m0 holds", c, 16'd100);
        gate_req = 3'h0;
        hw(8'h13, 8'h12);
        hw(8'h10, 8'h03);
        wl(0, 0, 60, c);
        chk("m1 wait", c, 16'd60);
        gate_req = 3'h1;
        wl(0, 0, 60, c);
        wl(0, 1, 100, lo);
        chk("m1 width", lo, 16'd24);
        $display("One-shot tests done");
        rst;
        results;
    end
endmodule
